//--- pcp_pkg.sv
// Functional notes
// - Forced trigger object configurable as one-bit or two-bit type.
// - Controller mode: forced state suspends control; output is configured forced brightness.
// - If allowed, bus brightness writes change output while forced.
// - Bus return, restore none: resume default state, no forcing.
// - Bus return, restore forced on: enter forced-on state.
// - Bus return, restore forced off: constant light controller mode.
// - Bus return, restore previous: restore forced state before bus loss.
// - Lock activated by ON or OFF telegram, selectable, when enabled.
// - On lock: only lock, or lock and send value, default 255.
// - Automatic unlock after configurable h:m:s delay, default 30 s.
// - Switch mode: lock over general operation.
// - Controller mode: lock, forced, manual, general in strict priority.
// - Manual mode ends after timeout up to 12 h; zero never ends.
package pcp_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SEC_NS        = 1_000_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  LOCK_VAL_DEF  = 8'hff;
  localparam logic [16:0] UNLOCK_S_DEF  = 17'h0001e;
  localparam logic [16:0] MANUAL_S_DEF  = 17'h00e10;
  localparam logic [16:0] MANUAL_S_MAX  = 17'h0a8c0;
  localparam logic [7:0]  BRIGHT_OFF    = 8'h00;

  typedef enum logic [1:0] {
    PCP_RST_NONE = 2'h0,
    PCP_RST_ON   = 2'h1,
    PCP_RST_OFF  = 2'h2,
    PCP_RST_PREV = 2'h3
  } pcp_restore_t;

  typedef enum logic [1:0] {
    PCP_SRC_GEN    = 2'h0,
    PCP_SRC_MANUAL = 2'h1,
    PCP_SRC_FORCED = 2'h3,
    PCP_SRC_LOCK   = 2'h2
  } pcp_src_t;

  typedef struct packed {
    logic         ctrl_mode;
    logic         force_2bit;
    logic [7:0]   force_value;
    logic         force_bus_chg;
    pcp_restore_t restore;
    logic         lock_en;
    logic         lock_on_pol;
    logic         lock_send;
    logic [7:0]   lock_value;
    logic         unlock_auto;
    logic [16:0]  unlock_s;
    logic [16:0]  manual_s;
  } pcp_cfg_t;

  typedef struct packed {
    logic       lock_stb;
    logic       lock_bit;
    logic       force_stb;
    logic [1:0] force_val;
    logic       bright_stb;
    logic [7:0] bright_val;
    logic       manual_stb;
    logic [7:0] manual_val;
  } pcp_tel_t;
endpackage : pcp_pkg

//--- pcp_sec_timer.sv
`timescale 1ns/1ps
module pcp_sec_timer
  import pcp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SEC_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Control
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [16:0] secs,
  // Status
  output logic             running,
  output logic             expire
);
  logic [31:0] pre_reg, pre_next;
  logic [16:0] cnt_reg, cnt_next;
  logic        run_reg, run_next;
  logic        exp_reg, exp_next;

  always_comb begin
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    run_next = run_reg;
    exp_next = 1'b0;
    if (start) begin
      pre_next = '0;
      cnt_next = secs;
      run_next = (secs != '0);
    end else if (stop) begin
      run_next = 1'b0;
    end else if (run_reg) begin
      if (pre_reg == 32'(TICK_CYCLES - 1)) begin
        pre_next = '0;
        if (cnt_reg == 17'h00001) begin
          run_next = 1'b0;
          exp_next = 1'b1;
        end
        cnt_next = cnt_reg - 17'h00001;
      end else begin
        pre_next = pre_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_reg <= '0;
      cnt_reg <= '0;
      run_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      exp_reg <= exp_next;
    end
  end

  assign running = run_reg;
  assign expire  = exp_reg;
endmodule : pcp_sec_timer

//--- pcp_channel.sv
`timescale 1ns/1ps
module pcp_channel
  import pcp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SEC_CYCLES
) (
  // Clock and reset
  input  wire logic     clock,
  input  wire logic     rstn,
  // Bus voltage return, one-cycle pulse
  input  wire logic     bus_return,
  // Configuration
  input  wire pcp_cfg_t cfg,
  // Telegrams from the bus
  input  wire pcp_tel_t tel,
  // Constant light loop output
  input  wire logic [7:0] general_val,
  // Channel output
  output logic [7:0]    out_val,
  output logic          out_send,
  output pcp_src_t      out_src,
  output logic          locked,
  output logic          forced,
  output logic          manual
);
  logic       lock_reg, lock_next;
  logic       force_reg, force_next;
  logic       saved_reg, saved_next;
  logic       man_reg, man_next;
  logic [7:0] fval_reg, fval_next;
  logic [7:0] mval_reg, mval_next;
  logic [7:0] out_reg, out_next;
  logic       send_reg, send_next;
  pcp_src_t   src_reg, src_next;
  logic       lock_go, lock_rel, force_go, force_rel;
  logic       unl_exp, man_exp;
  logic [16:0] man_secs;

  // Lock request decoding
  always_comb begin
    lock_go  = cfg.lock_en && tel.lock_stb &&
               (tel.lock_bit == cfg.lock_on_pol);
    lock_rel = (cfg.lock_en && tel.lock_stb &&
               (tel.lock_bit != cfg.lock_on_pol)) || unl_exp;
  end

  // Forced trigger: one-bit level, or two-bit control bit alone, value bit unused
  always_comb begin
    if (cfg.force_2bit) begin
      force_go  = tel.force_stb && tel.force_val[1];
      force_rel = tel.force_stb && !tel.force_val[1];
    end else begin
      force_go  = tel.force_stb && tel.force_val[0];
      force_rel = tel.force_stb && !tel.force_val[0];
    end
  end

  assign man_secs = (cfg.manual_s > MANUAL_S_MAX) ? MANUAL_S_MAX
                                                  : cfg.manual_s;

  pcp_sec_timer #(.TICK_CYCLES(TICK_CYCLES)) u_unlock (
    .clock   (clock),
    .rstn    (rstn),
    .start   (lock_go && !lock_reg && !bus_return && cfg.unlock_auto),
    .stop    (lock_rel || bus_return),
    .secs    (cfg.unlock_s),
    .running (),
    .expire  (unl_exp)
  );

  pcp_sec_timer #(.TICK_CYCLES(TICK_CYCLES)) u_manual (
    .clock   (clock),
    .rstn    (rstn),
    .start   (tel.manual_stb),
    .stop    (bus_return),
    .secs    (man_secs),
    .running (),
    .expire  (man_exp)
  );

  always_comb begin
    lock_next  = lock_reg;
    force_next = force_reg;
    saved_next = saved_reg;
    man_next   = man_reg;
    fval_next  = fval_reg;
    mval_next  = mval_reg;
    if (bus_return) begin
      lock_next = 1'b0;
      man_next  = 1'b0;
      fval_next = cfg.force_value;
      case (cfg.restore)
        PCP_RST_NONE: force_next = 1'b0;
        PCP_RST_ON:   force_next = 1'b1;
        PCP_RST_OFF:  force_next = 1'b0;
        PCP_RST_PREV: force_next = saved_reg;
        default:      force_next = 1'b0;
      endcase
    end else begin
      if (lock_go) begin
        lock_next = 1'b1;
      end else if (lock_rel) begin
        lock_next = 1'b0;
      end
      if (force_go) begin
        force_next = 1'b1;
        fval_next  = cfg.force_value;
      end else if (force_rel) begin
        force_next = 1'b0;
      end
      if (tel.bright_stb && force_reg && cfg.force_bus_chg) begin
        fval_next = tel.bright_val;
      end
      saved_next = force_next;
      if (tel.manual_stb && cfg.ctrl_mode) begin
        man_next  = 1'b1;
        mval_next = tel.manual_val;
      end else if (man_exp) begin
        man_next = 1'b0;
      end
    end
  end

  // Output arbitration, registered so a handover changes in one step
  always_comb begin
    send_next = 1'b0;
    if (lock_reg) begin
      src_next = PCP_SRC_LOCK;
      out_next = cfg.lock_send ? cfg.lock_value : out_reg;
      send_next = cfg.lock_send && (src_reg != PCP_SRC_LOCK);
    end else if (cfg.ctrl_mode && force_reg) begin
      src_next = PCP_SRC_FORCED;
      out_next = fval_reg;
    end else if (cfg.ctrl_mode && man_reg) begin
      src_next = PCP_SRC_MANUAL;
      out_next = mval_reg;
    end else begin
      src_next = PCP_SRC_GEN;
      out_next = general_val;
    end
    if (src_next != PCP_SRC_LOCK && out_next != out_reg) begin
      send_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock_reg  <= 1'b0;
      force_reg <= 1'b0;
      saved_reg <= 1'b0;
      man_reg   <= 1'b0;
      fval_reg  <= BRIGHT_OFF;
      mval_reg  <= BRIGHT_OFF;
      out_reg   <= BRIGHT_OFF;
      send_reg  <= 1'b0;
      src_reg   <= PCP_SRC_GEN;
    end else begin
      lock_reg  <= lock_next;
      force_reg <= force_next;
      saved_reg <= saved_next;
      man_reg   <= man_next;
      fval_reg  <= fval_next;
      mval_reg  <= mval_next;
      out_reg   <= out_next;
      send_reg  <= send_next;
      src_reg   <= src_next;
    end
  end

  assign out_val  = out_reg;
  assign out_send = send_reg;
  assign out_src  = src_reg;
  assign locked   = lock_reg;
  assign forced   = force_reg;
  assign manual   = man_reg;

  // Assertions
  a_lock_wins: assert property (@(posedge clock) disable iff (!rstn)
    lock_reg |=> src_reg == PCP_SRC_LOCK)
    else $error("lock not highest");
  a_forced_val: assert property (@(posedge clock) disable iff (!rstn)
    !lock_reg && cfg.ctrl_mode && force_reg |=> out_reg == $past(fval_reg))
    else $error("forced value wrong");
  a_lock_engage: assert property (@(posedge clock) disable iff (!rstn)
    lock_go && !bus_return |=> lock_reg)
    else $error("lock not engaged");
  a_lock_send: assert property (@(posedge clock) disable iff (!rstn)
    lock_reg && cfg.lock_send && src_reg != PCP_SRC_LOCK
    |=> out_send && out_reg == $past(cfg.lock_value))
    else $error("lock value not sent");
  a_unlock_exp: assert property (@(posedge clock) disable iff (!rstn)
    unl_exp && !lock_go && !bus_return |=> !lock_reg)
    else $error("auto unlock failed");
  a_restore_on: assert property (@(posedge clock) disable iff (!rstn)
    bus_return && cfg.restore == PCP_RST_ON |=> force_reg)
    else $error("restore on failed");
  a_restore_none: assert property (@(posedge clock) disable iff (!rstn)
    bus_return && cfg.restore != PCP_RST_ON
    && cfg.restore != PCP_RST_PREV |=> !force_reg)
    else $error("restore off failed");
  a_restore_prev: assert property (@(posedge clock) disable iff (!rstn)
    bus_return && cfg.restore == PCP_RST_PREV
    |=> force_reg == $past(saved_reg))
    else $error("restore previous failed");
  a_bus_change: assert property (@(posedge clock) disable iff (!rstn)
    tel.bright_stb && force_reg && !cfg.force_bus_chg && !force_go
    && !bus_return |=> fval_reg == $past(fval_reg))
    else $error("forced value changed");
  a_manual_exit: assert property (@(posedge clock) disable iff (!rstn)
    man_exp && !tel.manual_stb && !bus_return |=> !man_reg)
    else $error("manual not left");
  a_switch_mode: assert property (@(posedge clock) disable iff (!rstn)
    !cfg.ctrl_mode && !lock_reg |=> src_reg == PCP_SRC_GEN)
    else $error("switch mode source");

  // Lock request, then state, then output source one cycle later
  sequence s_lock_request;
    lock_go && !lock_reg && !bus_return;
  endsequence
  sequence s_lock_taken;
    lock_reg ##1 (src_reg == PCP_SRC_LOCK);
  endsequence
  a_lock_path: assert property (@(posedge clock) disable iff (!rstn)
    s_lock_request |=> s_lock_taken)
    else $error("lock handover late");
endmodule : pcp_channel

//--- pcp_bus_model.sv
`timescale 1ns/1ps
module pcp_bus_model
  import pcp_pkg::*;
(
  // Clock
  input  wire logic clock,
  // Bus side
  output pcp_tel_t  tel,
  output logic      bus_return
);
  initial begin
    tel = '0;
    bus_return = 1'b0;
  end
  // Kind 0 lock, 1 forced, 2 brightness, 3 manual, 4 bus return
  task automatic send(input int k, input logic [7:0] v);
    pcp_tel_t t;
    // Edge first, so a release of the previous call has settled
    @(posedge clock);
    t = tel;
    case (k)
      0: begin t.lock_stb = 1'b1; t.lock_bit = v[0]; end
      1: begin t.force_stb = 1'b1; t.force_val = v[1:0]; end
      2: begin t.bright_stb = 1'b1; t.bright_val = v; end
      3: begin t.manual_stb = 1'b1; t.manual_val = v; end
      default: ;
    endcase
    tel <= t;
    bus_return <= (k == 4);
    @(posedge clock);
    // Released data lines show no stale value
    t = ~t;
    t.lock_stb = 1'b0;
    t.force_stb = 1'b0;
    t.bright_stb = 1'b0;
    t.manual_stb = 1'b0;
    tel <= t;
    bus_return <= 1'b0;
  endtask : send
endmodule : pcp_bus_model

//--- pcp_channel_tb_top.sv
`timescale 1ns/1ps
module pcp_channel_tb_top
  import pcp_pkg::*;
;
  logic       clock;
  logic       rstn;
  pcp_cfg_t   cfg;
  pcp_tel_t   tel;
  logic       bus_return;
  logic [7:0] general_val;
  logic [7:0] out_val;
  logic       out_send;
  pcp_src_t   out_src;
  logic       locked;
  logic       forced;
  logic       manual;
  int         n_mismatch;
  int         cmp_count;

  pcp_bus_model m (.clock(clock), .tel(tel), .bus_return(bus_return));
  pcp_channel #(.TICK_CYCLES(10)) dut (
    .clock(clock), .rstn(rstn), .bus_return(bus_return), .cfg(cfg),
    .tel(tel), .general_val(general_val), .out_val(out_val),
    .out_send(out_send), .out_src(out_src), .locked(locked),
    .forced(forced), .manual(manual));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic pcp_cfg_t base();
    pcp_cfg_t c;
    c = '0;
    c.ctrl_mode = 1'b1;
    c.force_value = 8'hfc;
    c.lock_en = 1'b1;
    c.lock_on_pol = 1'b1;
    c.lock_send = 1'b1;
    c.lock_value = LOCK_VAL_DEF;
    c.unlock_s = UNLOCK_S_DEF;
    c.manual_s = MANUAL_S_DEF;
    return c;
  endfunction : base

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : w

  task automatic restart(input pcp_cfg_t c);
    @(posedge clock);
    rstn <= 1'b0;
    cfg <= c;
    @(posedge clock);
    rstn <= 1'b1;
    w(4);
  endtask : restart

  task automatic step(input int k, input logic [7:0] v, e,
                      input pcp_src_t s);
    m.send(k, v);
    w(3);
    chk("out_val", e, out_val);
    chk("out_src", s, out_src);
  endtask : step

  task automatic t_lock();
    pcp_cfg_t c;
    for (int p = 0; p < 2; p++) begin
      c = base();
      c.lock_on_pol = p[0];
      c.lock_send = p[0];
      restart(c);
      m.send(0, {7'h00, ~p[0]});
      w(3);
      chk("locked", 1'b0, locked);
      m.send(0, {7'h00, p[0]});
      w(1);
      chk("out_send", p[0], out_send);
      chk("out_val", p[0] ? 8'hff : 8'h40, out_val);
      w(1);
      chk("out_send", 1'b0, out_send);
      chk("out_src", PCP_SRC_LOCK, out_src);
    end
  endtask : t_lock

  task automatic t_prio();
    restart(base());
    step(3, 8'h21, 8'h21, PCP_SRC_MANUAL);
    step(1, 8'h01, 8'hfc, PCP_SRC_FORCED);
    step(0, 8'h01, 8'hff, PCP_SRC_LOCK);
    step(0, 8'h00, 8'hfc, PCP_SRC_FORCED);
    step(1, 8'h00, 8'h21, PCP_SRC_MANUAL);
  endtask : t_prio

  task automatic t_switch();
    pcp_cfg_t c;
    c = base();
    c.ctrl_mode = 1'b0;
    restart(c);
    step(1, 8'h01, 8'h40, PCP_SRC_GEN);
    step(3, 8'h21, 8'h40, PCP_SRC_GEN);
    step(0, 8'h01, 8'hff, PCP_SRC_LOCK);
  endtask : t_switch

  task automatic t_force();
    pcp_cfg_t c;
    for (int b = 0; b < 2; b++) begin
      c = base();
      c.force_2bit = b[0];
      c.force_bus_chg = b[0];
      restart(c);
      step(1, 8'h01, b ? 8'h40 : 8'hfc, b ? PCP_SRC_GEN : PCP_SRC_FORCED);
      step(1, 8'h03, 8'hfc, PCP_SRC_FORCED);
      step(2, 8'h80, b ? 8'h80 : 8'hfc, PCP_SRC_FORCED);
    end
  endtask : t_force

  task automatic t_timers();
    pcp_cfg_t c;
    c = base();
    c.unlock_auto = 1'b1;
    c.unlock_s = 17'h00003;
    restart(c);
    m.send(0, 8'h01);
    w(20);
    chk("locked", 1'b1, locked);
    w(20);
    chk("locked", 1'b0, locked);
    chk("out_src", PCP_SRC_GEN, out_src);
    for (int s = 0; s < 3; s += 2) begin
      c = base();
      c.manual_s = 17'(s);
      restart(c);
      m.send(3, 8'h21);
      w(14);
      chk("manual", 1'b1, manual);
      w(14);
      chk("manual", s == 0, manual);
    end
  endtask : t_timers

  task automatic t_restore();
    pcp_cfg_t c;
    logic     e;
    for (int r = 0; r < 4; r++) begin
      c = base();
      c.restore = pcp_restore_t'(r[1:0]);
      e = (r == 1) || (r == 3);
      restart(c);
      if (r != 1) m.send(1, 8'h01);
      w(3);
      m.send(4, 8'h00);
      w(3);
      chk("forced", e, forced);
      chk("out_val", e ? 8'hfc : 8'h40, out_val);
    end
  endtask : t_restore

  initial begin
    rstn = 1'b0;
    cfg = base();
    general_val = 8'h40;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_lock();
    t_prio();
    t_switch();
    t_force();
    t_timers();
    t_restore();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end
endmodule : pcp_channel_tb_top
